// File: hrcs_pkg.sv
package hrcs_pkg;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS      = 10;
   localparam int unsigned RECOVER_US         = 500;
   localparam int unsigned RECOVER_CYC        = RECOVER_US * 1000 / CLK_PERIOD_NS;
   localparam int unsigned INACTIVE_US        = 2;
   localparam int unsigned INACTIVE_CYC       = INACTIVE_US * 1000 / CLK_PERIOD_NS;
   localparam int unsigned ATTACH_MS          = 100;
   localparam int unsigned ATTACH_CYC         = ATTACH_MS * 100000;
   localparam int unsigned EE_CFG_US10        = 995;
   localparam int unsigned EE_CFG_CYC         = EE_CFG_US10 * 10000;
   localparam int unsigned BP_LOAD_CYC        = EE_CFG_US10 * 10000;
   localparam int unsigned REQ_MS             = 5;
   localparam int unsigned REQ_CYC            = REQ_MS * 100000;

   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_PORT_CFG       = 8'h00;
   localparam logic [7:0] ADDR_DEV_ADDR       = 8'h01;
   localparam logic [7:0] ADDR_SEQ_STAT       = 8'h02;
   localparam logic [7:0] ADDR_STAT_CMD       = 8'hff;
   localparam int unsigned CMD_ATTACH_BIT     = 0;
   localparam int unsigned CMD_RESET_BIT      = 1;
   localparam int unsigned CMD_PWDN_BIT       = 2;
   localparam logic [7:0] RST_VAL             = 8'h00;

   // ---------------------------------------------------------------
   // strap encoding and types
   // ---------------------------------------------------------------
   localparam logic [1:0] CFG_DEFAULT         = 2'b00;
   localparam logic [1:0] CFG_SMBUS           = 2'b01;

   typedef enum logic [1:0] {
      HRCS_SRC_STRAP,
      HRCS_SRC_EEPROM,
      HRCS_SRC_SMBUS
   } hrcs_src_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } hrcs_req_t;

   typedef struct packed {
      logic       bus_reset;
      logic       suspended;
      logic       req_start;
      logic       req_done;
   } hrcs_usb_t;

endpackage : hrcs_pkg

// File: hrcs_top.sv
`timescale 1ns/1ps
`default_nettype none

// How it works
// - reset disables ports, drops downstream power
// - reset disables transceivers, pairs high-impedance
// - reset aborts transactions, keeps nothing
// - reset returns registers to zero
// - reset stops oscillator and PLL
// - operational 500 us later, straps pick source
// - both straps low uses defaults, strap options
// - strap mode: inactive outputs, attach within 100 ms
// - EEPROM mode: config within 99.5 ms, attach
// - after code load attach within 100 ms
// - self-powered no load limit, bus-powered 99.5 ms
// - control requests complete within 5 ms
// - bus reset zeroes address, unconfigures
// - bus reset drops power, flushes TT buffers
// - bus reset wakes a suspended hub
// - bus reset never forwarded downstream
// - START then STOP idles SMBus slave
// - undefined registers read zero, writes ignored
// - SMBus mode waits, attaches only after load
// - attach bit attaches, write-protects 00h-FEh
module hrcs_top
   import hrcs_pkg::*;
#(
   parameter int unsigned RECOVER_N  = RECOVER_CYC,
   parameter int unsigned ATTACH_N   = ATTACH_CYC,
   parameter int unsigned EE_CFG_N   = EE_CFG_CYC,
   parameter int unsigned BP_LOAD_N  = BP_LOAD_CYC,
   parameter int unsigned REQ_N      = REQ_CYC,
   parameter int unsigned PORTS      = 4
) (
   input  wire logic                 CLK_SYS_I,
   input  wire logic                 RST_I,
   input  wire logic                 CONFIG_STRAP_HI_I,
   input  wire logic                 CONFIG_STRAP_LO_I,
   input  wire logic [PORTS-1:0]     PORT_DISABLE_STRAP_I,
   input  wire logic                 BUS_POWERED_I,
   input  wire logic                 EE_DONE_I,
   input  wire logic                 SMB_START_I,
   input  wire logic                 SMB_STOP_I,
   input  wire logic                 SMB_BIT_I,
   input  wire hrcs_pkg::hrcs_req_t  REQ_I,
   input  wire hrcs_pkg::hrcs_usb_t  USB_I,
   output logic [7:0]                RDATA_O,
   output logic [PORTS-1:0]          DOWNSTREAM_POWER_ENABLE_O,
   output logic [PORTS-1:0]          PORT_ENABLE_O,
   output logic                      PHY_ENABLE_O,
   output logic                      OSC_ENABLE_O,
   output logic                      USB_ATTACH_O,
   output logic                      EE_START_O,
   output logic                      TT_FLUSH_O,
   output logic                      WAKE_O,
   output logic                      SMB_IDLE_O,
   output logic                      CFG_FAIL_O,
   output logic                      REQ_TIMEOUT_O
);
   import hrcs_pkg::*;

   // ---------------------------------------------------------------
   // sequencer state
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_RECOVER,
      ST_SELECT,
      ST_EE_LOAD,
      ST_SMB_LOAD,
      ST_ATTACH_WAIT,
      ST_ATTACHED
   } hrcs_state_t;

   hrcs_state_t     state_r;
   hrcs_src_t       src_r;
   logic [31:0]     cnt_r;
   logic [31:0]     req_cnt_r;
   logic            req_busy_r;
   logic            smb_start_seen_r;
   logic            configured_r;
   logic [7:0]      dev_addr_r;
   logic [7:0]      port_cfg_r;
   logic [7:0]      stat_cmd_r;
   logic            protect;
   logic [31:0]     attach_age_r;

   // write-protect everything below FFh once the attach bit is set
   assign protect = stat_cmd_r[CMD_ATTACH_BIT];

   function automatic logic defined_addr(input logic [7:0] a);
      defined_addr = (a == ADDR_PORT_CFG) || (a == ADDR_DEV_ADDR) ||
                     (a == ADDR_SEQ_STAT) || (a == ADDR_STAT_CMD);
   endfunction : defined_addr

   // ---------------------------------------------------------------
   // start-up sequencer
   // ---------------------------------------------------------------
   // all sequencing restarts from RST_I; counting begins at release
   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         state_r    <= ST_RECOVER;
         src_r      <= HRCS_SRC_STRAP;
         cnt_r      <= 32'h0000_0000;
         CFG_FAIL_O <= 1'b0;
         EE_START_O <= 1'b0;
      end else begin
         EE_START_O <= 1'b0;
         unique case (state_r)
            ST_RECOVER: begin
               // delay after oscillator restart
               if (cnt_r >= RECOVER_N - 1) begin
                  cnt_r   <= 32'h0000_0000;
                  state_r <= ST_SELECT;
               end else begin
                  cnt_r <= cnt_r + 32'h0000_0001;
               end
            end
            ST_SELECT: begin
               // straps are sampled once, after recovery
               if ({CONFIG_STRAP_HI_I, CONFIG_STRAP_LO_I} == CFG_DEFAULT) begin
                  src_r   <= HRCS_SRC_STRAP;
                  state_r <= ST_ATTACH_WAIT;
               end else if ({CONFIG_STRAP_HI_I, CONFIG_STRAP_LO_I} == CFG_SMBUS) begin
                  src_r   <= HRCS_SRC_SMBUS;
                  state_r <= ST_SMB_LOAD;
               end else begin
                  src_r      <= HRCS_SRC_EEPROM;
                  EE_START_O <= 1'b1;
                  state_r    <= ST_EE_LOAD;
               end
            end
            ST_EE_LOAD: begin
               if (EE_DONE_I) begin
                  cnt_r   <= 32'h0000_0000;
                  state_r <= ST_ATTACH_WAIT;
               end else if (cnt_r >= EE_CFG_N - 1) begin
                  CFG_FAIL_O <= 1'b1; // load overran; fall back to defaults
                  cnt_r      <= 32'h0000_0000;
                  state_r    <= ST_ATTACH_WAIT;
               end else begin
                  cnt_r <= cnt_r + 32'h0000_0001;
               end
            end
            ST_SMB_LOAD: begin
               // self-powered waits without limit
               if (protect) begin
                  cnt_r   <= 32'h0000_0000;
                  state_r <= ST_ATTACH_WAIT;
               end else if (BUS_POWERED_I && cnt_r >= BP_LOAD_N - 1) begin
                  CFG_FAIL_O <= 1'b1;
                  cnt_r      <= cnt_r;
               end else begin
                  cnt_r <= cnt_r + 32'h0000_0001;
               end
            end
            ST_ATTACH_WAIT: begin
               // ST_ATTACHED one cycle later, USB_ATTACH_O the cycle after, well inside the window
               state_r <= ST_ATTACHED;
            end
            ST_ATTACHED: begin
               state_r <= ST_ATTACHED;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // pin outputs
   // ---------------------------------------------------------------
   // everything inactive under reset; attach only at the end
   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         DOWNSTREAM_POWER_ENABLE_O <= '0;
         PORT_ENABLE_O             <= '0;
         PHY_ENABLE_O              <= 1'b0;
         OSC_ENABLE_O              <= 1'b0;
         USB_ATTACH_O              <= 1'b0;
         TT_FLUSH_O                <= 1'b0;
         WAKE_O                    <= 1'b0;
      end else begin
         OSC_ENABLE_O <= 1'b1;
         PHY_ENABLE_O <= (state_r == ST_ATTACHED);
         USB_ATTACH_O <= (state_r == ST_ATTACHED);
         TT_FLUSH_O   <= USB_I.bus_reset;
         WAKE_O       <= USB_I.bus_reset && USB_I.suspended;
         // bus reset only drops power; ports stay, nothing forwarded
         if (USB_I.bus_reset || !configured_r) begin
            DOWNSTREAM_POWER_ENABLE_O <= '0;
         end else begin
            DOWNSTREAM_POWER_ENABLE_O <= ~PORT_DISABLE_STRAP_I;
         end
         if (state_r == ST_ATTACHED) begin
            PORT_ENABLE_O <= ~(PORT_DISABLE_STRAP_I | port_cfg_r[PORTS-1:0]);
         end else begin
            PORT_ENABLE_O <= '0;
         end
      end
   end

   // ---------------------------------------------------------------
   // usb device state
   // ---------------------------------------------------------------
   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         dev_addr_r   <= RST_VAL;
         configured_r <= 1'b0;
      end else if (USB_I.bus_reset) begin
         dev_addr_r   <= RST_VAL;
         configured_r <= 1'b0;
      end else if (REQ_I.wr && REQ_I.addr == ADDR_DEV_ADDR && !protect) begin
         dev_addr_r   <= REQ_I.wdata;
         configured_r <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // control request watchdog
   // ---------------------------------------------------------------
   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         req_busy_r    <= 1'b0;
         req_cnt_r     <= 32'h0000_0000;
         REQ_TIMEOUT_O <= 1'b0;
      end else if (USB_I.req_start) begin
         req_busy_r    <= 1'b1;
         req_cnt_r     <= 32'h0000_0000;
         // an old request timing out in this same cycle keeps its flag
         REQ_TIMEOUT_O <= req_busy_r && !USB_I.req_done && (req_cnt_r >= REQ_N - 1);
      end else if (req_busy_r) begin
         if (USB_I.req_done) begin
            req_busy_r <= 1'b0;
         end else if (req_cnt_r >= REQ_N - 1) begin
            req_busy_r    <= 1'b0;
            REQ_TIMEOUT_O <= 1'b1;
         end else begin
            req_cnt_r <= req_cnt_r + 32'h0000_0001;
         end
      end
   end

   // ---------------------------------------------------------------
   // smbus slave bus-reset detection
   // ---------------------------------------------------------------
   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         smb_start_seen_r <= 1'b0;
         SMB_IDLE_O       <= 1'b1;
      end else if (SMB_START_I) begin
         smb_start_seen_r <= 1'b1;
         SMB_IDLE_O       <= 1'b0;
      end else if (SMB_STOP_I) begin
         smb_start_seen_r <= 1'b0;
         SMB_IDLE_O       <= 1'b1;
      end else if (SMB_BIT_I) begin
         smb_start_seen_r <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // configuration registers
   // ---------------------------------------------------------------
   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         port_cfg_r <= RST_VAL;
         stat_cmd_r <= RST_VAL;
      end else if (stat_cmd_r[CMD_RESET_BIT]) begin
         port_cfg_r <= RST_VAL;
         stat_cmd_r <= RST_VAL;
      end else if (REQ_I.wr) begin
         if (REQ_I.addr == ADDR_PORT_CFG && !protect) begin
            port_cfg_r <= REQ_I.wdata;
         end
         if (REQ_I.addr == ADDR_STAT_CMD) begin
            stat_cmd_r <= {5'h00, REQ_I.wdata[2:0]} | {7'h00, stat_cmd_r[CMD_ATTACH_BIT]};
         end
      end
   end

   // ---------------------------------------------------------------
   // read port
   // ---------------------------------------------------------------
   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         RDATA_O <= 8'h00;
      end else if (REQ_I.rd) begin
         if (!defined_addr(REQ_I.addr)) begin
            RDATA_O <= 8'h00;
         end else if (REQ_I.addr == ADDR_PORT_CFG) begin
            RDATA_O <= port_cfg_r;
         end else if (REQ_I.addr == ADDR_DEV_ADDR) begin
            RDATA_O <= dev_addr_r;
         end else if (REQ_I.addr == ADDR_SEQ_STAT) begin
            RDATA_O <= {2'b00, CFG_FAIL_O, configured_r, src_r, USB_ATTACH_O, smb_start_seen_r};
         end else begin
            RDATA_O <= stat_cmd_r;
         end
      end else begin
         RDATA_O <= 8'h00;
      end
   end

   // ---------------------------------------------------------------
   // attach deadline
   // ---------------------------------------------------------------
   // age of a finished configuration that has not attached yet
   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         attach_age_r <= 32'h0000_0000;
      end else if (state_r == ST_ATTACH_WAIT || (state_r == ST_ATTACHED && !USB_ATTACH_O)) begin
         attach_age_r <= attach_age_r + 32'h0000_0001;
      end else begin
         attach_age_r <= 32'h0000_0000;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (RST_I);

   no_early_attach_a: assert property (USB_ATTACH_O |-> state_r == ST_ATTACHED)
      else $error("attach before sequence end");
   pwr_bus_reset_a: assert property (USB_I.bus_reset |=> DOWNSTREAM_POWER_ENABLE_O == '0)
      else $error("power not dropped");
   addr_bus_reset_a: assert property (USB_I.bus_reset |=> dev_addr_r == 8'h00 && !configured_r)
      else $error("address not cleared");
   wake_a: assert property (USB_I.bus_reset && USB_I.suspended |=> WAKE_O)
      else $error("no wake");
   undef_read_a: assert property (REQ_I.rd && !defined_addr(REQ_I.addr) |=> RDATA_O == 8'h00)
      else $error("undefined read nonzero");
   protect_wr_a: assert property (protect && REQ_I.wr && REQ_I.addr == ADDR_PORT_CFG
                                  && !stat_cmd_r[CMD_RESET_BIT] |=> $stable(port_cfg_r))
      else $error("protected write landed");
   smb_idle_a: assert property (SMB_START_I ##1 (SMB_STOP_I && !SMB_START_I) |=> SMB_IDLE_O)
      else $error("smbus not idle");
   smb_wait_a: assert property (state_r == ST_SMB_LOAD && !protect |=> !USB_ATTACH_O)
      else $error("attach before load");
   attach_after_a: assert property (state_r == ST_ATTACH_WAIT |-> ##2 USB_ATTACH_O)
      else $error("attach late");
   recover_a: assert property ($fell(RST_I) |-> state_r == ST_RECOVER)
      else $error("not recovering");
   osc_run_a: assert property (!RST_I |=> OSC_ENABLE_O)
      else $error("oscillator not running");
   ee_pulse_a: assert property (EE_START_O |=> !EE_START_O)
      else $error("load start too long");
   strap_select_a: assert property (state_r == ST_SELECT && {CONFIG_STRAP_HI_I, CONFIG_STRAP_LO_I} == CFG_DEFAULT |=> state_r == ST_ATTACH_WAIT && src_r == HRCS_SRC_STRAP)
      else $error("strap mode not taken");
   tt_flush_a: assert property (USB_I.bus_reset |=> TT_FLUSH_O)
      else $error("buffers not flushed");
   smb_busy_a: assert property (SMB_START_I |=> !SMB_IDLE_O)
      else $error("smbus idle after start");
   self_power_a: assert property (state_r == ST_SMB_LOAD && !BUS_POWERED_I |-> !CFG_FAIL_O)
      else $error("self-powered load limited");
   undef_write_a: assert property (REQ_I.wr && !defined_addr(REQ_I.addr) && !USB_I.bus_reset && !stat_cmd_r[CMD_RESET_BIT]
                                   |=> $stable(port_cfg_r) && $stable(stat_cmd_r) && $stable(dev_addr_r))
      else $error("undefined write landed");
   attach_deadline_a: assert property (attach_age_r < ATTACH_N)
      else $error("attach deadline missed");
   timeout_flag_a: assert property (req_busy_r && !USB_I.req_done && req_cnt_r >= REQ_N - 1 |=> REQ_TIMEOUT_O)
      else $error("request timeout lost");

   strap_c: cover property (state_r == ST_SELECT ##1 src_r == HRCS_SRC_STRAP);
   ee_c:    cover property (state_r == ST_EE_LOAD ##1 state_r == ST_ATTACH_WAIT);
   smb_c:   cover property (state_r == ST_SMB_LOAD ##1 state_r == ST_ATTACH_WAIT);
   rst_c:   cover property (USB_ATTACH_O && USB_I.bus_reset);
   to_c:    cover property (REQ_TIMEOUT_O);

endmodule : hrcs_top

`default_nettype wire

// File: hrcs_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// --------------------------------------------
// upstream host model
// --------------------------------------------
module hrcs_host_model
   import hrcs_pkg::*;
#(
   parameter int unsigned GAP_N = 40
) (
   input  wire logic           clk_i,
   input  wire logic           rst_i,
   input  wire logic           attach_i,
   input  wire logic           bus_reset_i,
   input  wire logic           suspend_i,
   input  wire logic           go_i,
   input  wire logic           slow_i,
   output hrcs_pkg::hrcs_usb_t usb_o
);
   int unsigned since_r;
   int unsigned left_r;

   // time since attach, a bus reset waits until the gap is over
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) since_r <= 0;
      else if (!attach_i) since_r <= 0;
      else if (since_r < GAP_N) since_r <= since_r + 1;
   end

   // bus state and control requests, answered fast or too slow
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         usb_o  <= '0;
         left_r <= 0;
      end else begin
         usb_o.bus_reset <= bus_reset_i && since_r >= GAP_N;
         usb_o.suspended <= suspend_i;
         usb_o.req_start <= go_i && left_r == 0;
         usb_o.req_done  <= left_r == 1;
         if (go_i && left_r == 0) left_r <= slow_i ? 60 : 3;
         else if (left_r != 0) left_r <= left_r - 1;
      end
   end
endmodule : hrcs_host_model

`default_nettype wire

// File: hrcs_top_tb.sv
`timescale 1ns/1ps
`default_nettype none

module hrcs_top_tb;
   import hrcs_pkg::*;
   localparam int RN = 20;
   localparam int EN = 50;
   localparam int QN = 30;
   logic       clk = 1'b0, rst = 1'b1, s_hi = 1'b0, s_lo = 1'b0, bus_pwr = 1'b0;
   logic       ee_done = 1'b0, smb_st = 1'b0, smb_sp = 1'b0, smb_b = 1'b0;
   logic       br_req = 1'b0, susp = 1'b0, go = 1'b0, slow = 1'b0, rd_seen = 1'b0;
   logic [3:0] dis = 4'h0;
   hrcs_req_t  req = '0;
   hrcs_usb_t  usb;
   logic [7:0] rdata, v0, v1;
   logic [3:0] pwr, pen;
   logic       phy, osc, att, ee_st, ttf, wake, idle, cfail, rto;
   logic [7:0] exp_q[$];
   int         fail_count = 0, checks = 0;

   // --------------------------------------------
   // clock, design and host
   // --------------------------------------------
   always #5 clk = ~clk;

   hrcs_top #(
      .RECOVER_N (RN),
      .ATTACH_N  (200),
      .EE_CFG_N  (EN),
      .BP_LOAD_N (EN),
      .REQ_N     (QN)
   ) hrcs_top_inst (
      .CLK_SYS_I                 (clk),
      .RST_I                     (rst),
      .CONFIG_STRAP_HI_I         (s_hi),
      .CONFIG_STRAP_LO_I         (s_lo),
      .PORT_DISABLE_STRAP_I      (dis),
      .BUS_POWERED_I             (bus_pwr),
      .EE_DONE_I                 (ee_done),
      .SMB_START_I               (smb_st),
      .SMB_STOP_I                (smb_sp),
      .SMB_BIT_I                 (smb_b),
      .REQ_I                     (req),
      .USB_I                     (usb),
      .RDATA_O                   (rdata),
      .DOWNSTREAM_POWER_ENABLE_O (pwr),
      .PORT_ENABLE_O             (pen),
      .PHY_ENABLE_O              (phy),
      .OSC_ENABLE_O              (osc),
      .USB_ATTACH_O              (att),
      .EE_START_O                (ee_st),
      .TT_FLUSH_O                (ttf),
      .WAKE_O                    (wake),
      .SMB_IDLE_O                (idle),
      .CFG_FAIL_O                (cfail),
      .REQ_TIMEOUT_O             (rto)
   );

   hrcs_host_model hrcs_host_model_inst (
      .clk_i       (clk),
      .rst_i       (rst),
      .attach_i    (att),
      .bus_reset_i (br_req),
      .suspend_i   (susp),
      .go_i        (go),
      .slow_i      (slow),
      .usb_o       (usb)
   );

   // --------------------------------------------
   // checking and bus tasks
   // --------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] want);
      checks++;
      if (got !== want) begin
         fail_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, want);
      end
   endtask : chk

   task automatic complete_run;
      if (fail_count == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : complete_run

   // read data is compared in the cycle after the strobe was taken
   always @(posedge clk) begin
      if (rd_seen) chk(rdata, exp_q.pop_front());
      rd_seen <= req.rd;
   end

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      req <= '0;
      @(posedge clk);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] want);
      exp_q.push_back(want);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      req <= '0;
      repeat (2) @(posedge clk);
   endtask : rd

   function automatic logic pick(input int k);
      case (k)
         0: return att;
         1: return cfail;
         2: return rto;
         3: return ee_st;
         default: return ttf;
      endcase
   endfunction : pick

   // bounded wait for an output, arrival must fall inside lo..hi cycles
   task automatic wait_hi(input int k, input int lo, input int hi);
      int n;
      n = 0;
      while (pick(k) !== 1'b1 && n <= hi) begin
         @(posedge clk);
         n++;
      end
      checks++;
      if (n < lo || n > hi) begin
         fail_count++;
         $display("unexpected at %0t: output %0d after %0d cycles", $time, k, n);
         complete_run();
      end
   endtask : wait_hi

   task automatic restart(input logic [1:0] strap, input logic bp);
      rst <= 1'b1;
      {s_hi, s_lo} <= strap;
      bus_pwr <= bp;
      repeat (4) @(posedge clk);
      chk({pwr, pen}, 8'h00);
      chk({phy, osc, att, idle}, 8'h01);
      rst <= 1'b0;
      @(posedge clk);
   endtask : restart

   // --------------------------------------------
   // scenarios
   // --------------------------------------------
   initial begin
      void'($urandom(32'ha91f23b7));
      dis <= 4'($urandom % 15);
      // default mode: straps, undefined register, bus reset
      restart(2'b00, 1'b0);
      wait_hi(0, RN - 2, RN + 8);
      chk(pen, 4'(~dis));
      chk({phy, osc}, 8'h03);
      v0 = 8'($urandom_range(254, 3));
      wr(v0, 8'($urandom));
      rd(v0, 8'h00);
      v1 = 8'($urandom_range(127, 1));
      wr(ADDR_DEV_ADDR, v1);
      rd(ADDR_DEV_ADDR, v1);
      chk(|pwr, 1'b1);
      br_req <= 1'b1;
      susp <= 1'b1;
      wait_hi(4, 0, 60);
      @(posedge clk);
      chk({pwr, wake, ttf}, 8'h03);
      chk(pen, 4'(~dis));
      br_req <= 1'b0;
      susp <= 1'b0;
      repeat (3) @(posedge clk);
      rd(ADDR_DEV_ADDR, 8'h00);
      // control requests answered fast and too slow
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (QN + 6) @(posedge clk);
      chk(rto, 1'b0);
      slow <= 1'b1;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      wait_hi(2, QN - 1, QN + 6);
      // mid-run reset into self-powered code-load mode
      wr(ADDR_PORT_CFG, 8'h05);
      restart(2'b01, 1'b0);
      rd(ADDR_PORT_CFG, 8'h00);
      repeat (RN + 60) @(posedge clk);
      chk({cfail, att}, 8'h00);
      smb_st <= 1'b1;
      @(posedge clk);
      smb_st <= 1'b0;
      smb_b <= 1'b1;
      @(posedge clk);
      chk(idle, 1'b0);
      smb_b <= 1'b0;
      smb_st <= 1'b1;
      @(posedge clk);
      smb_st <= 1'b0;
      smb_sp <= 1'b1;
      @(posedge clk);
      smb_sp <= 1'b0;
      @(posedge clk);
      chk(idle, 1'b1);
      // bus-powered code load, attach and write protection
      restart(2'b01, 1'b1);
      wait_hi(1, EN - 2, RN + EN + 8);
      chk(att, 1'b0);
      wr(ADDR_PORT_CFG, 8'h0a);
      wr(ADDR_STAT_CMD, 8'h01);
      wait_hi(0, 0, 6);
      wr(ADDR_PORT_CFG, 8'h03);
      rd(ADDR_PORT_CFG, 8'h0a);
      rd(ADDR_SEQ_STAT, {2'b00, 1'b1, 1'b0, HRCS_SRC_SMBUS, 1'b1, 1'b0});
      wr(ADDR_STAT_CMD, 8'h02);
      rd(ADDR_PORT_CFG, 8'h00);
      rd(ADDR_STAT_CMD, 8'h00);
      // serial memory load, completed and timed out
      restart(2'b10, 1'b0);
      wait_hi(3, RN - 2, RN + 8);
      chk(att, 1'b0);
      ee_done <= 1'b1;
      @(posedge clk);
      ee_done <= 1'b0;
      wait_hi(0, 0, 6);
      restart(2'b11, 1'b0);
      wait_hi(1, EN - 2, RN + EN + 8);
      complete_run();
   end
endmodule : hrcs_top_tb

`default_nettype wire
